/* File: hw/i2c_port_pkg.sv */
/*
 * Constants, types and decode helpers for the two-wire slave control port.
 * Assumes a 20 MHz core clock and pins that are already open-drain
 * resolved outside the block.
 */
`default_nettype none
package i2c_port_pkg;
	localparam logic [4:0] ADDR_FIXED = 5'h13;
	localparam int IDX_W = 7;
	localparam logic [6:0] IDX_ONE = 7'h01;
	localparam logic [6:0] IDX_RESET = 7'h00;
	localparam logic [6:0] DEF_FIRST = 7'h10;
	localparam logic [6:0] DEF_LAST = 7'h16;
	localparam logic [6:0] RD_FIRST = 7'h10;
	localparam logic [6:0] RD_LAST = 7'h1F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BITS_LAST = 4'h7;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_CYC = SPIKE_CYC + 1;

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK,
		S_WDAT, S_WACK, S_TX, S_MACK, S_WAIT
	} state_t;

	function automatic logic is_defined(input logic [6:0] idx);
		return (idx >= DEF_FIRST) && (idx <= DEF_LAST);
	endfunction : is_defined

	function automatic logic is_readable(input logic [6:0] idx);
		return (idx >= RD_FIRST) && (idx <= RD_LAST);
	endfunction : is_readable
endpackage : i2c_port_pkg
`default_nettype wire

/* File: hw/reg_bus_if.sv */
/*
 * Register access carrier between the protocol engine and the store.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
	logic we;
	logic [6:0] waddr;
	logic [7:0] wdata;
	logic [6:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport store (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : reg_bus_if
`default_nettype wire

/* File: hw/glitch_filter.sv */
/*
 * Two-flop synchroniser followed by a stability counter for one line.
 * Assumes the line idles high, as a pulled-up bus line does.
 */
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
	parameter int STABLE = 2
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic pin,
	output logic level
);
	import i2c_port_pkg::*;

	logic s1_ff;
	logic s2_ff;
	logic level_ff;
	logic [3:0] cnt_ff;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
		end
		else
		begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
		end
	end

	// A spike shorter than STABLE samples never reaches the level
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			level_ff <= 1'b1;
			cnt_ff <= 4'h0;
		end
		else if (s2_ff == level_ff)
			cnt_ff <= 4'h0;
		else if (cnt_ff == 4'(STABLE - 1))
		begin
			level_ff <= s2_ff;
			cnt_ff <= 4'h0;
		end
		else
			cnt_ff <= cnt_ff + 4'h1;
	end

	assign level = level_ff;

	AST_FILT_STABLE: assert property (
		@(posedge core_clk) disable iff (srst)
		$changed(level_ff) |-> $past(cnt_ff) == 4'(STABLE - 1)
			&& $past(s2_ff) == level_ff)
		else $error("filter level changed before stable count");
endmodule : glitch_filter
`default_nettype wire

/* File: hw/reg_store.sv */
/*
 * Sixteen byte mode register store covering indices 0x10 to 0x1F.
 * Assumes the writer only presents defined indices; read data is registered.
 */
`timescale 1ns/1ps
`default_nettype none
module reg_store #(
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic srst,
	reg_bus_if.store rb
);
	import i2c_port_pkg::*;

	logic [7:0] mem_ff [DEPTH];
	logic [7:0] rdata_ff;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= REG_RESET;
		end
		else if (rb.we && is_readable(rb.waddr))
			mem_ff[rb.waddr[3:0]] <= rb.wdata;
	end

	// Unbacked indices in the window still answer with stored bytes
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rdata_ff <= REG_RESET;
		else if (is_readable(rb.raddr))
			rdata_ff <= mem_ff[rb.raddr[3:0]];
		else
			rdata_ff <= REG_RESET;
	end

	assign rb.rdata = rdata_ff;
endmodule : reg_store
`default_nettype wire

/* File: hw/i2c_slave_register_port.sv */
/*
 * Two-wire slave control port: address match, indexed register write
 * and read with auto-increment, spike filtering on both lines.
 * Assumes SDA is open-drain, resolved outside from serial_out_pin_oe,
 * and all pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_port (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic control_if_select,
	input wire logic port_select_pin,
	input wire logic serial_in_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_out_pin_in,
	output logic serial_out_pin_out,
	output logic serial_out_pin_oe,
	output logic wr_strobe,
	output logic [i2c_port_pkg::IDX_W-1:0] wr_index,
	output logic [7:0] wr_data,
	output logic busy
);
	import i2c_port_pkg::*;

	logic [2:0] pin_s1_ff;
	logic [2:0] pin_s2_ff;
	logic [2:0] pin_raw;
	logic sel;
	logic [1:0] addr_low;
	logic scl;
	logic sda;
	logic scl_d_ff;
	logic sda_d_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	state_t st_ff;
	logic [7:0] sh_ff;
	logic [7:0] tx_ff;
	logic [3:0] bits_ff;
	logic [6:0] idx_ff;
	logic rw_ff;
	logic wrote_ff;
	logic mack_ff;
	logic oe_ff;
	logic sda_out_ff;
	logic wr_strobe_ff;
	logic [6:0] wr_index_ff;
	logic [7:0] wr_data_ff;
	logic busy_ff;
	logic addr_match;
	logic byte_done;

	reg_bus_if rb ();

	// Select, address-bit-1 and address-bit-0 pins are all asynchronous
	assign pin_raw = {control_if_select, serial_in_pin, port_select_pin};

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_pin_sync
			always_ff @(posedge core_clk)
			begin
				if (srst)
				begin
					pin_s1_ff[g] <= 1'b0;
					pin_s2_ff[g] <= 1'b0;
				end
				else
				begin
					pin_s1_ff[g] <= pin_raw[g];
					pin_s2_ff[g] <= pin_s1_ff[g];
				end
			end
		end
	endgenerate

	assign sel = pin_s2_ff[2];
	assign addr_low = pin_s2_ff[1:0];

	// Filter depth covers the fast-mode spike width at this clock rate
	glitch_filter #(.STABLE(FILT_CYC)) u_scl_filt (
		.core_clk(core_clk),
		.srst(srst),
		.pin(serial_clock_pin),
		.level(scl)
	);

	glitch_filter #(.STABLE(FILT_CYC)) u_sda_filt (
		.core_clk(core_clk),
		.srst(srst),
		.pin(serial_out_pin_in),
		.level(sda)
	);

	reg_store #(.DEPTH(16)) u_store (
		.core_clk(core_clk),
		.srst(srst),
		.rb(rb.store)
	);

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_d_ff <= scl;
			sda_d_ff <= sda;
		end
	end

	assign scl_rise = scl && !scl_d_ff;
	assign scl_fall = !scl && scl_d_ff;
	// Slow clocks stretch filter delay; marginal start hold may be lost
	assign start_cond = scl && scl_d_ff && sda_d_ff && !sda;
	// Long spikes near SCL fall can fake these at fast clocks
	assign stop_cond = scl && scl_d_ff && !sda_d_ff && sda;
	assign addr_match = sh_ff[7:1] == {ADDR_FIXED, addr_low};
	assign byte_done = bits_ff == BITS_BYTE;

	// Data is captured on the filtered rising edge only
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sh_ff <= 8'h00;
			mack_ff <= 1'b0;
		end
		else if (scl_rise)
		begin
			sh_ff <= {sh_ff[6:0], sda};
			mack_ff <= !sda;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			bits_ff <= 4'h0;
		else if (start_cond || !sel)
			bits_ff <= 4'h0;
		else if (scl_rise && st_ff inside {S_ADDR, S_REG, S_WDAT})
			bits_ff <= bits_ff + 4'h1;
		else if (scl_fall && st_ff == S_TX)
			bits_ff <= bits_ff + 4'h1;
		else if (scl_fall && st_ff inside {S_AACK, S_RACK, S_WACK, S_MACK})
			bits_ff <= 4'h0;
	end

	// Protocol engine; start and stop outrank any bit activity
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			st_ff <= S_IDLE;
			oe_ff <= 1'b0;
			rw_ff <= 1'b0;
			tx_ff <= 8'h00;
		end
		else if (!sel)
		begin
			st_ff <= S_IDLE;
			oe_ff <= 1'b0;
		end
		else if (start_cond)
		begin
			st_ff <= S_ADDR;
			oe_ff <= 1'b0;
		end
		else if (stop_cond)
		begin
			st_ff <= S_IDLE;
			oe_ff <= 1'b0;
		end
		else if (scl_fall)
		begin
			unique case (st_ff)
				S_IDLE, S_WAIT:
					oe_ff <= 1'b0;
				S_ADDR:
					if (byte_done && addr_match)
					begin
						st_ff <= S_AACK;
						oe_ff <= 1'b1;
						rw_ff <= sh_ff[0];
					end
					else if (byte_done)
						st_ff <= S_WAIT;
				S_AACK:
					if (rw_ff)
					begin
						st_ff <= S_TX;
						tx_ff <= rb.rdata;
						oe_ff <= !rb.rdata[7];
					end
					else
					begin
						st_ff <= S_REG;
						oe_ff <= 1'b0;
					end
				S_REG:
					if (byte_done && is_defined(sh_ff[6:0]))
					begin
						st_ff <= S_RACK;
						oe_ff <= 1'b1;
					end
					else if (byte_done)
						st_ff <= S_WAIT;
				S_RACK, S_WACK:
				begin
					st_ff <= S_WDAT;
					oe_ff <= 1'b0;
				end
				S_WDAT:
					if (byte_done && is_defined(idx_ff))
					begin
						st_ff <= S_WACK;
						oe_ff <= 1'b1;
					end
					else if (byte_done)
						st_ff <= S_WAIT;
				S_TX:
					if (bits_ff == BITS_LAST)
					begin
						st_ff <= S_MACK;
						oe_ff <= 1'b0;
					end
					else
					begin
						tx_ff <= {tx_ff[6:0], 1'b0};
						oe_ff <= !tx_ff[6];
					end
				S_MACK:
					if (mack_ff)
					begin
						st_ff <= S_TX;
						tx_ff <= rb.rdata;
						oe_ff <= !rb.rdata[7];
					end
					else
						st_ff <= S_WAIT;
				default:
				begin
					st_ff <= S_IDLE;
					oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// Index: set by the register byte, stepped by writes and reads
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			idx_ff <= IDX_RESET;
			wrote_ff <= 1'b0;
		end
		else if (sel && !start_cond && !stop_cond && scl_fall)
		begin
			if (st_ff == S_ADDR && byte_done && addr_match)
			begin
				wrote_ff <= 1'b0;
				if (sh_ff[0] && wrote_ff)
					idx_ff <= idx_ff - IDX_ONE;
			end
			else if (st_ff == S_REG && byte_done && is_defined(sh_ff[6:0]))
				idx_ff <= sh_ff[6:0];
			else if (st_ff == S_WDAT && byte_done && is_defined(idx_ff))
			begin
				idx_ff <= idx_ff + IDX_ONE;
				wrote_ff <= 1'b1;
			end
		end
		else if (sel && scl_rise && st_ff == S_MACK)
			idx_ff <= idx_ff + IDX_ONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			wr_strobe_ff <= 1'b0;
			wr_index_ff <= IDX_RESET;
			wr_data_ff <= REG_RESET;
		end
		else if (sel && !start_cond && !stop_cond && scl_fall
			&& st_ff == S_WDAT && byte_done && is_defined(idx_ff))
		begin
			wr_strobe_ff <= 1'b1;
			wr_index_ff <= idx_ff;
			wr_data_ff <= sh_ff;
		end
		else
			wr_strobe_ff <= 1'b0;
	end

	// Open-drain: the line is only ever pulled low, never driven high
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			sda_out_ff <= 1'b0;
			busy_ff <= 1'b0;
		end
		else
		begin
			sda_out_ff <= 1'b0;
			busy_ff <= st_ff != S_IDLE;
		end
	end

	assign rb.we = wr_strobe_ff;
	assign rb.waddr = wr_index_ff;
	assign rb.wdata = wr_data_ff;
	assign rb.raddr = idx_ff;
	assign serial_out_pin_out = sda_out_ff;
	assign serial_out_pin_oe = oe_ff;
	assign wr_strobe = wr_strobe_ff;
	assign wr_index = wr_index_ff;
	assign wr_data = wr_data_ff;
	assign busy = busy_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	AST_SPI_QUIET: assert property (
		!sel |=> !oe_ff && st_ff == S_IDLE)
		else $error("line driven while two-wire mode deselected");

	AST_ADDR_ACK: assert property (
		sel && scl_fall && !start_cond && !stop_cond && st_ff == S_ADDR
		&& byte_done && addr_match |=> oe_ff && st_ff == S_AACK)
		else $error("matching address not acknowledged");

	AST_ADDR_MISS: assert property (
		sel && scl_fall && st_ff == S_ADDR && byte_done && !addr_match
		|=> !oe_ff [*2])
		else $error("foreign address touched the bus");

	AST_OPEN_DRAIN: assert property (
		oe_ff |-> !sda_out_ff)
		else $error("data line driven high");

	AST_WR_DEFINED: assert property (
		wr_strobe_ff |-> is_defined(wr_index_ff) && $past(st_ff) == S_WDAT)
		else $error("write to undefined register");

	AST_WR_INC: assert property (
		wr_strobe_ff |-> idx_ff == wr_index_ff + IDX_ONE)
		else $error("index not advanced after write byte");

	AST_RD_INC: assert property (
		sel && scl_rise && st_ff == S_MACK && !start_cond && !stop_cond
		|=> idx_ff == $past(idx_ff) + IDX_ONE)
		else $error("index not advanced after sent byte");

	AST_IDX_WRAP: assert property (
		sel && scl_rise && st_ff == S_MACK && idx_ff == 7'h7F
		|=> idx_ff == IDX_RESET)
		else $error("index did not wrap to zero");

	AST_RD_AFTER_WR: assert property (
		sel && scl_fall && !start_cond && st_ff == S_ADDR && byte_done
		&& addr_match && sh_ff[0] && wrote_ff
		|=> idx_ff == $past(idx_ff) - IDX_ONE ##1 !wrote_ff)
		else $error("first read after write did not return written reg");

	COV_WRITE: cover property (wr_strobe_ff ##[1:1000] st_ff == S_WACK);
	COV_READ_TWO: cover property (st_ff == S_MACK ##[1:1000] st_ff == S_TX);
	COV_REG_NACK: cover property (st_ff == S_REG ##1 st_ff == S_WAIT);
endmodule : i2c_slave_register_port
`default_nettype wire

/* File: testbench/i2c_master_model.sv */
/*
 * Two-wire bus master model driving the slave port from the far side.
 * Assumes the bench resolves sda from both open-drain drivers and a
 * pull-up; glitch is set by the bench only around write bytes.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	output var logic scl,
	output var logic sda_oe,
	input wire logic sda
);
	// Link tick; phases are whole ticks so fast-mode low and high hold
	localparam int LNK = 400;
	logic glitch;
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
		glitch = 1'b0;
	end
	task automatic start();
		sda_oe = 1'b0;
		#(LNK);
		scl = 1'b1;
		#(2*LNK);
		sda_oe = 1'b1;
		#(2*LNK);
		scl = 1'b0;
		#(LNK);
	endtask : start
	task automatic stop();
		sda_oe = 1'b1;
		#(LNK);
		scl = 1'b1;
		#(2*LNK);
		sda_oe = 1'b0;
		#(2*LNK);
	endtask : stop
	// Spikes are 40 ns and some 1.2 us apart, so the filter must hold
	task automatic bit_io(input logic v, output logic s);
		sda_oe = !v;
		#(LNK);
		if (glitch)
		begin
			scl = 1'b1;
			#40;
			scl = 1'b0;
		end
		#(2*LNK);
		scl = 1'b1;
		#(LNK);
		if (glitch && v)
		begin
			sda_oe = 1'b1;
			#40;
			sda_oe = 1'b0;
		end
		#(2*LNK-10);
		s = sda;
		#10;
		scl = 1'b0;
		#(LNK);
	endtask : bit_io
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = (s === 1'b0);
	endtask : wr_byte
	// Refusing the last byte tells the slave to let go of the bus
	task automatic rd_byte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(!more, s);
	endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

/* File: testbench/i2c_slave_register_port_bench.sv */
/*
 * Self-checking bench for the two-wire slave register port.
 * Assumes the master model above and a pull-up on the data line.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_port_bench;
	import i2c_port_pkg::*;
	localparam logic [7:0] AW = {ADDR_FIXED, 3'b110};
	localparam logic [7:0] AR = {ADDR_FIXED, 3'b111};
	logic core_clk, srst, sel, ad0, ad1, scl, m_oe, sda;
	logic oe, dout, wr_strobe, busy, oe_seen;
	logic [IDX_W-1:0] wr_index;
	logic [7:0] wr_data;
	logic [7:0] exp_mem [128];
	logic [14:0] wq [$];
	int n_mismatch, total_checks;
	assign sda = !m_oe & (oe ? dout : 1'b1);
	i2c_slave_register_port i_dut (.core_clk(core_clk), .srst(srst),
		.control_if_select(sel), .port_select_pin(ad0),
		.serial_in_pin(ad1), .serial_clock_pin(scl),
		.serial_out_pin_in(sda), .serial_out_pin_out(dout),
		.serial_out_pin_oe(oe), .wr_strobe(wr_strobe),
		.wr_index(wr_index), .wr_data(wr_data), .busy(busy));
	i2c_master_model i_master (.scl(scl), .sda_oe(m_oe), .sda(sda));
	always @(posedge core_clk)
	begin
		if (oe === 1'b1)
			oe_seen <= 1'b1;
		if (wr_strobe === 1'b1)
			wq.push_back({wr_index, wr_data});
	end
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic put(input logic [7:0] b, input logic ea);
		logic a;
		i_master.wr_byte(b, a);
		chk1(a, ea);
	endtask : put
	task automatic get(input logic more, input logic [7:0] e);
		logic [7:0] b;
		i_master.rd_byte(more, b);
		chk8(b, e);
	endtask : get
	// An empty queue yields index 0x7F, which no write can report here
	task automatic chk_wr(input logic [6:0] idx, input logic [7:0] d);
		logic [14:0] w;
		w = 15'h7FFF;
		if (wq.size() > 0)
			w = wq.pop_front();
		chk8({1'b0, w[14:8]}, {1'b0, idx});
		chk8(w[7:0], d);
		exp_mem[idx] = d;
	endtask : chk_wr
	function automatic logic [7:0] exp_rd(input logic [6:0] i);
		return (i >= 7'h10 && i <= 7'h1F) ? exp_mem[i] : 8'h00;
	endfunction : exp_rd
	task automatic t_addr();
		logic [1:0] a;
		for (int k = 0; k < 4; k++)
		begin
			a = k[1:0];
			@(posedge core_clk);
			#1;
			ad0 = a[0];
			ad1 = a[1];
			repeat (6) @(posedge core_clk);
			i_master.start();
			put({ADDR_FIXED, a, 1'b0}, 1'b1);
			put(8'h10, 1'b1);
			put({6'h28, a}, 1'b1);
			i_master.stop();
			chk_wr(7'h10, {6'h28, a});
			oe_seen = 1'b0;
			i_master.start();
			put({ADDR_FIXED, ~a, 1'b0}, 1'b0);
			put(8'h10, 1'b0);
			i_master.stop();
			chk1(oe_seen, 1'b0);
			chk1(wq.size() == 0, 1'b1);
		end
	endtask : t_addr
	task automatic t_select();
		@(posedge core_clk);
		#1;
		sel = 1'b0;
		repeat (4) @(posedge core_clk);
		oe_seen = 1'b0;
		i_master.start();
		put(AW, 1'b0);
		i_master.stop();
		chk1(oe_seen, 1'b0);
		@(posedge core_clk);
		#1;
		sel = 1'b1;
		repeat (6) @(posedge core_clk);
	endtask : t_select
	task automatic t_burst();
		i_master.start();
		put(AW, 1'b1);
		put(8'h14, 1'b1);
		for (int k = 0; k < 3; k++)
			put(8'h11 * (k[7:0] + 8'h01), 1'b1);
		put(8'h44, 1'b0);
		chk1(busy, 1'b1);
		i_master.stop();
		repeat (4) @(posedge core_clk);
		chk1(busy, 1'b0);
		for (int k = 0; k < 3; k++)
			chk_wr(7'h14 + k[6:0], 8'h11 * (k[7:0] + 8'h01));
		chk1(wq.size() == 0, 1'b1);
		i_master.start();
		put(AW, 1'b1);
		put(8'h20, 1'b0);
		i_master.stop();
	endtask : t_burst
	task automatic t_rdwr();
		i_master.start();
		put(AW, 1'b1);
		put(8'h12, 1'b1);
		put(8'h5A, 1'b1);
		i_master.start();
		put(AR, 1'b1);
		get(1'b1, 8'h5A);
		get(1'b1, exp_mem[7'h13]);
		get(1'b0, exp_mem[7'h14]);
		i_master.stop();
		chk_wr(7'h12, 8'h5A);
	endtask : t_rdwr
	// Runs the index from 0x16 past 0x7F and back round to 0x10
	task automatic t_wrap();
		i_master.start();
		put(AW, 1'b1);
		put(8'h16, 1'b1);
		i_master.start();
		put(AR, 1'b1);
		for (int k = 0; k < 123; k++)
			get(k < 122, exp_rd(7'h16 + k[6:0]));
		i_master.stop();
	endtask : t_wrap
	task automatic t_glitch();
		i_master.glitch = 1'b1;
		i_master.start();
		put(AW, 1'b1);
		put(8'h11, 1'b1);
		put(8'hC3, 1'b1);
		i_master.glitch = 1'b0;
		i_master.stop();
		chk_wr(7'h11, 8'hC3);
	endtask : t_glitch
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		// About 4.2 ms of traffic; the limit stays under 100k core cycles
		#4800000;
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		srst = 1'b1;
		sel = 1'b1;
		ad0 = 1'b1;
		ad1 = 1'b1;
		oe_seen = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
		for (int i = 0; i < 128; i++)
			exp_mem[i] = 8'h00;
		repeat (2) @(posedge core_clk);
		#1;
		srst = 1'b0;
		repeat (6) @(posedge core_clk);
		chk1(busy, 1'b0);
		chk1(oe, 1'b0);
		t_addr();
		t_select();
		t_burst();
		t_rdwr();
		t_wrap();
		t_glitch();
		wrap_up();
	end
endmodule : i2c_slave_register_port_bench
`default_nettype wire
